// ==== hdl/rtcs_top.sv ====
// Real-time counter with periodic tick timer behind an AHB-Lite slave.
//
// What this block does
// - Counter runs in idle sleep; in standby only when keep_running_in_standby set.
// - Periodic tick timer keeps running in every sleep mode.
// - Counting uses the selected real-time tick; updates apply after synchronisation.
// - Status busy bits 3..0 flag compare, period, count, control A syncing.
// - Periodic status bit 0 flags periodic control synchronisation in progress.
// - Control A: standby bit 7, prescaler 6:3, enable bit 0, reset zero.
// - Prescaler divides the real-time tick by two to the prescaler code.
// - Control A updates apply two real-time ticks after write, busy meanwhile.
// - Interrupt enables: match at bit 1, wrap at bit 0, reset zero.
// - Overflow means counter equalled the limit and wrapped to zero.
// - Match flag bit 1 sets when counter equals compare; write one clears.
// - Wrap flag bit 0 sets on wrap to zero; write one clears.
// - One shared eight-bit temporary register at index 0x4, reset zero.
// - Temporary register makes byte accesses to 16-bit registers atomic.
// - Interrupt asserts while an enable and its flag are both set.
// - Source select: 0 fast, 1 slow, 3 external pin, 2 reserved.
//
// Added by the designer: the AHB-Lite register port.
module rtcs_top
    import rtcs_pkg::*;
(
    input  wire logic        hclk,          // Bus clock
    input  wire logic        hresetn,       // Asynchronous reset, active low
    input  wire logic        hsel,          // Slave select
    input  wire logic [7:0]  haddr,         // Byte address
    input  wire logic [1:0]  htrans,        // Transfer type
    input  wire logic        hwrite,        // Write when high
    input  wire logic [2:0]  hsize,         // Transfer size, word only
    input  wire logic [31:0] hwdata,        // Write data
    input  wire logic        hready,        // Bus ready
    output logic      [31:0] hrdata,        // Read data
    output logic             hreadyout,     // Slave ready
    output logic             hresp,         // Always OKAY
    input  wire logic        fast_src_tick, // Internal fast source tick
    input  wire logic        ext_src_tick,  // External source tick
    input  wire logic [1:0]  sleep_mode,    // 0 active, 1 idle, 2 standby
    input  wire logic        dbg_halt,      // Processor halted by debugger
    output logic             irq,           // Interrupt request, level
    output logic             wrap_event,    // Wrap strobe, one cycle
    output logic             match_event    // Match strobe, one cycle
);
    import rtcs_pkg::*;

    // ********************************************************
    // State
    // ********************************************************
    typedef struct packed {
        logic                   dp_valid;
        logic                   dp_write;
        logic [5:0]             dp_idx;
        logic                   rd_done;
        logic [7:0]             rdata;
        logic [7:0]             control_a;
        logic [7:0]             control_a_app;
        logic [1:0]             irq_en;
        logic [1:0]             irq_flag;
        logic [7:0]             temp;
        logic                   dbg_run;
        logic [1:0]             tick_source_select;
        logic [15:0]            cnt;
        logic [15:0]            cnt_wr;
        logic [15:0]            wrap_limit;
        logic [15:0]            per_app;
        logic [15:0]            cmp;
        logic [15:0]            cmp_app;
        logic [7:0]             pitctrl;
        logic [7:0]             pit_app;
        logic                   pit_en;
        logic                   pit_flag;
        logic                   pit_dbg_run;
        logic [NSYNC-1:0]       pend;
        logic [NSYNC-1:0][1:0]  sc;
        logic [14:0]            presc;
        logic [4:0]             slow_div;
        logic                   wrap_evt;
        logic                   match_evt;
    } rtcs_state_t;

    rtcs_state_t s_r;
    rtcs_state_t s_nxt;

    // Mask of the low prescaler bits that must all be one for a tick.
    function automatic logic [14:0] rtcs_low_mask(input logic [4:0] bits);
        rtcs_low_mask = 15'((16'h0001 << bits) - 16'h0001);
    endfunction : rtcs_low_mask

    // ********************************************************
    // Next-state logic
    // ********************************************************
    logic             slow_tick;
    logic             rtc_ce;
    logic [NSYNC-1:0] apply;
    logic             presc_run;
    logic             cnt_run;
    logic             pit_run;
    logic             cnt_tick;
    logic [15:0]      cnt_next;
    logic [1:0]       flag_set;
    logic [1:0]       flag_clr;
    logic             pit_set;
    logic             pit_clr;
    logic [14:0]      ps_mask;
    logic [14:0]      pit_mask;
    logic             rd_cycle;
    logic [7:0]       wd;

    always_comb begin
        s_nxt     = s_r;
        flag_set  = 2'h0;
        flag_clr  = 2'h0;
        pit_set   = 1'b0;
        pit_clr   = 1'b0;
        cnt_tick  = 1'b0;
        cnt_next  = s_r.cnt;
        apply     = '0;
        wd        = hwdata[7:0];
        s_nxt.wrap_evt  = 1'b0;
        s_nxt.match_evt = 1'b0;

        // Real-time tick source selection.
        slow_tick = fast_src_tick && (s_r.slow_div == SLOW_DIV_MAX);
        if (fast_src_tick) begin
            s_nxt.slow_div = s_r.slow_div + 5'h01;
        end
        case (s_r.tick_source_select)
            SRC_FAST: rtc_ce = fast_src_tick;
            SRC_SLOW: rtc_ce = slow_tick;
            SRC_EXT:  rtc_ce = ext_src_tick;
            default:  rtc_ce = 1'b0;
        endcase

        // Control A, count, period, compare and periodic control writes reach the counting logic only after two ticks.
        for (int i = 0; i < NSYNC; i++) begin
            if (s_r.pend[i] && rtc_ce) begin
                if (s_r.sc[i] == SYNC_TICKS - 2'h1) begin
                    apply[i]       = 1'b1;
                    s_nxt.pend[i]  = 1'b0;
                end else begin
                    s_nxt.sc[i] = s_r.sc[i] + 2'h1;
                end
            end
        end
        if (apply[SY_CA]) begin
            s_nxt.control_a_app = s_r.control_a;
        end
        if (apply[SY_PER]) begin
            s_nxt.per_app = s_r.wrap_limit;
        end
        if (apply[SY_CMP]) begin
            s_nxt.cmp_app = s_r.cmp;
        end
        if (apply[SY_PIT]) begin
            s_nxt.pit_app = s_r.pitctrl;
        end

        // Shared prescaler.
        presc_run = s_r.control_a_app[CA_EN] || s_r.pit_app[CA_EN];
        if (!presc_run) begin
            s_nxt.presc = 15'h0000;
        end else if (rtc_ce) begin
            s_nxt.presc = s_r.presc + 15'h0001;
        end

        // Counter.
        cnt_run = s_r.control_a_app[CA_EN]
               && !(sleep_mode == SLP_STANDBY
                    && !s_r.control_a_app[CA_STDBY])
               && !(dbg_halt && !s_r.dbg_run);
        ps_mask = rtcs_low_mask({1'b0, s_r.control_a_app[CA_PS_LSB +: 4]});
        if (rtc_ce && cnt_run && ((s_r.presc & ps_mask) == ps_mask)) begin
            cnt_tick = 1'b1;
        end
        if (apply[SY_CNT]) begin
            s_nxt.cnt = s_r.cnt_wr;
        end else if (cnt_tick) begin
            if (s_r.cnt == s_r.per_app) begin
                cnt_next = 16'h0000;
                flag_set[IRQ_WRAP] = 1'b1;
                s_nxt.wrap_evt = 1'b1;
            end else begin
                cnt_next = s_r.cnt + 16'h0001;
            end
            if (cnt_next == s_r.cmp_app) begin
                flag_set[IRQ_MATCH] = 1'b1;
                s_nxt.match_evt = 1'b1;
            end
            s_nxt.cnt = cnt_next;
        end

        // Periodic tick timer: period is 2 to the (code + 1) ticks.
        pit_run  = s_r.pit_app[CA_EN]
                && !(dbg_halt && !s_r.pit_dbg_run);
        pit_mask = rtcs_low_mask({1'b0, s_r.pit_app[CA_PS_LSB +: 4]}
                                 + 5'h01);
        if (rtc_ce && pit_run
            && s_r.pit_app[CA_PS_LSB +: 4] != PIT_OFF
            && s_r.pit_app[CA_PS_LSB +: 4] != PIT_RSVD
            && ((s_r.presc & pit_mask) == pit_mask)) begin
            pit_set = 1'b1;
        end

        // AHB-Lite: writes complete with no wait, reads take one wait.
        rd_cycle = s_r.dp_valid && !s_r.dp_write && !s_r.rd_done;
        if (s_r.dp_valid && s_r.dp_write) begin
            case (s_r.dp_idx)
                IDX_CONTROL_A: begin
                    s_nxt.control_a       = wd & CA_WMASK;
                    s_nxt.pend[SY_CA] = 1'b1;
                    s_nxt.sc[SY_CA]   = 2'h0;
                end
                IDX_IRQ_ENABLES:  s_nxt.irq_en   = wd[1:0];
                IDX_IRQ_FLAGS: flag_clr       = wd[1:0];
                IDX_TEMP:     s_nxt.temp     = wd;
                IDX_DBG:      s_nxt.dbg_run  = wd[0];
                IDX_TICK_SOURCE_SELECT:   s_nxt.tick_source_select   = wd[1:0];
                IDX_CNTL, IDX_PERL, IDX_CMPL: begin
                    s_nxt.temp = wd;
                end
                IDX_CNTH: begin
                    s_nxt.cnt_wr       = {wd, s_r.temp};
                    s_nxt.pend[SY_CNT] = 1'b1;
                    s_nxt.sc[SY_CNT]   = 2'h0;
                end
                IDX_PERH: begin
                    s_nxt.wrap_limit          = {wd, s_r.temp};
                    s_nxt.pend[SY_PER] = 1'b1;
                    s_nxt.sc[SY_PER]   = 2'h0;
                end
                IDX_CMPH: begin
                    s_nxt.cmp          = {wd, s_r.temp};
                    s_nxt.pend[SY_CMP] = 1'b1;
                    s_nxt.sc[SY_CMP]   = 2'h0;
                end
                IDX_PITCTRL: begin
                    s_nxt.pitctrl      = wd & PIT_WMASK;
                    s_nxt.pend[SY_PIT] = 1'b1;
                    s_nxt.sc[SY_PIT]   = 2'h0;
                end
                IDX_PITINTEN: s_nxt.pit_en      = wd[0];
                IDX_PITFLAG:  pit_clr           = wd[0];
                IDX_PITDBG:   s_nxt.pit_dbg_run = wd[0];
                default: ;
            endcase
        end
        if (rd_cycle) begin
            s_nxt.rd_done = 1'b1;
            case (s_r.dp_idx)
                IDX_CONTROL_A:    s_nxt.rdata = s_r.control_a;
                IDX_STATUS:   s_nxt.rdata = {4'h0, s_r.pend[3:0]};
                IDX_IRQ_ENABLES:  s_nxt.rdata = {6'h00, s_r.irq_en};
                IDX_IRQ_FLAGS: s_nxt.rdata = {6'h00, s_r.irq_flag};
                IDX_TEMP:     s_nxt.rdata = s_r.temp;
                IDX_DBG:      s_nxt.rdata = {7'h00, s_r.dbg_run};
                IDX_TICK_SOURCE_SELECT:   s_nxt.rdata = {6'h00, s_r.tick_source_select};
                IDX_CNTL: begin
                    s_nxt.rdata = s_r.cnt[7:0];
                    s_nxt.temp  = s_r.cnt[15:8];
                end
                IDX_PERL: begin
                    s_nxt.rdata = s_r.wrap_limit[7:0];
                    s_nxt.temp  = s_r.wrap_limit[15:8];
                end
                IDX_CMPL: begin
                    s_nxt.rdata = s_r.cmp[7:0];
                    s_nxt.temp  = s_r.cmp[15:8];
                end
                IDX_CNTH, IDX_PERH, IDX_CMPH: begin
                    s_nxt.rdata = s_r.temp;
                end
                IDX_PITCTRL:  s_nxt.rdata = s_r.pitctrl;
                IDX_PITSTAT:  s_nxt.rdata = {7'h00, s_r.pend[SY_PIT]};
                IDX_PITINTEN: s_nxt.rdata = {7'h00, s_r.pit_en};
                IDX_PITFLAG:  s_nxt.rdata = {7'h00, s_r.pit_flag};
                IDX_PITDBG:   s_nxt.rdata = {7'h00, s_r.pit_dbg_run};
                default:      s_nxt.rdata = 8'h00;
            endcase
        end
        if (hready) begin
            s_nxt.rd_done = 1'b0;
            s_nxt.dp_valid = hsel && htrans[1];
            s_nxt.dp_write = hwrite;
            s_nxt.dp_idx   = haddr[7:2];
        end

        // A flag event in the clearing cycle is kept.
        s_nxt.irq_flag = (s_r.irq_flag & ~flag_clr) | flag_set;
        s_nxt.pit_flag = (s_r.pit_flag & ~pit_clr) | pit_set;
    end

    // ********************************************************
    // State register
    // ********************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r         <= '0;
            s_r.wrap_limit     <= PER_RST;
            s_r.per_app <= PER_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    assign hreadyout   = !(s_r.dp_valid && !s_r.dp_write && !s_r.rd_done);
    assign hresp       = 1'b0;
    assign hrdata      = {24'h000000, s_r.rdata};
    assign irq         = (|(s_r.irq_en & s_r.irq_flag))
                      || (s_r.pit_en && s_r.pit_flag);
    assign wrap_event  = s_r.wrap_evt;
    assign match_event = s_r.match_evt;

endmodule : rtcs_top

// ==== common/rtcs_pkg.sv ====
// Constants shared by the real-time counter control block.
package rtcs_pkg;

    // ********************************************************
    // Register indices; byte address is four times the index
    // ********************************************************
    localparam logic [5:0] IDX_CONTROL_A    = 6'h00;
    localparam logic [5:0] IDX_STATUS   = 6'h01;
    localparam logic [5:0] IDX_IRQ_ENABLES  = 6'h02;
    localparam logic [5:0] IDX_IRQ_FLAGS = 6'h03;
    localparam logic [5:0] IDX_TEMP     = 6'h04;
    localparam logic [5:0] IDX_DBG      = 6'h05;
    localparam logic [5:0] IDX_TICK_SOURCE_SELECT   = 6'h07;
    localparam logic [5:0] IDX_CNTL     = 6'h08;
    localparam logic [5:0] IDX_CNTH     = 6'h09;
    localparam logic [5:0] IDX_PERL     = 6'h0a;
    localparam logic [5:0] IDX_PERH     = 6'h0b;
    localparam logic [5:0] IDX_CMPL     = 6'h0c;
    localparam logic [5:0] IDX_CMPH     = 6'h0d;
    localparam logic [5:0] IDX_PITCTRL  = 6'h10;
    localparam logic [5:0] IDX_PITSTAT  = 6'h11;
    localparam logic [5:0] IDX_PITINTEN = 6'h12;
    localparam logic [5:0] IDX_PITFLAG  = 6'h13;
    localparam logic [5:0] IDX_PITDBG   = 6'h15;

    // ********************************************************
    // Field positions and write masks
    // ********************************************************
    localparam int unsigned CA_STDBY   = 7;
    localparam int unsigned CA_PS_LSB  = 3;
    localparam int unsigned CA_EN      = 0;
    localparam int unsigned IRQ_MATCH  = 1;
    localparam int unsigned IRQ_WRAP   = 0;
    localparam logic [7:0]  CA_WMASK   = 8'hf9;
    localparam logic [7:0]  PIT_WMASK  = 8'h79;

    // Synchronisation slots; slots 3..0 match the busy bit positions.
    localparam int unsigned SY_CA  = 0;
    localparam int unsigned SY_CNT = 1;
    localparam int unsigned SY_PER = 2;
    localparam int unsigned SY_CMP = 3;
    localparam int unsigned SY_PIT = 4;
    localparam int unsigned NSYNC  = 5;

    // ********************************************************
    // Reset values, codes and counts
    // ********************************************************
    localparam logic [15:0] PER_RST      = 16'hffff;
    localparam logic [1:0]  SYNC_TICKS   = 2'h2;
    localparam logic [4:0]  SLOW_DIV_MAX = 5'h1f;
    localparam logic [1:0]  SRC_FAST     = 2'h0;
    localparam logic [1:0]  SRC_SLOW     = 2'h1;
    localparam logic [1:0]  SRC_EXT      = 2'h3;
    localparam logic [1:0]  SLP_STANDBY  = 2'h2;
    localparam logic [3:0]  PIT_OFF      = 4'h0;
    localparam logic [3:0]  PIT_RSVD     = 4'hf;

endpackage : rtcs_pkg

// ==== dv/rtcs_properties.sv ====
// Checker of bus timing, interrupt and event behaviour of the counter block.
module rtcs_properties (
    input wire logic        hclk,          // Bus clock
    input wire logic        hresetn,       // Reset, active low
    input wire logic        hsel,          // Slave select
    input wire logic [1:0]  htrans,        // Transfer type
    input wire logic        hwrite,        // Write when high
    input wire logic        hready,        // Bus ready
    input wire logic [31:0] hrdata,        // Read data
    input wire logic        hreadyout,     // Slave ready
    input wire logic        hresp,         // Response
    input wire logic        fast_src_tick, // Fast source tick
    input wire logic        ext_src_tick,  // External source tick
    input wire logic        irq,           // Interrupt request
    input wire logic        wrap_event,    // Wrap strobe
    input wire logic        match_event    // Match strobe
);
    // ********************************************************
    // Helper logic
    // ********************************************************
    logic take_w;
    logic take_r;
    logic tk;
    logic wr_dp_r;

    assign take_w = hsel && htrans[1] && hready && hwrite;
    assign take_r = hsel && htrans[1] && hready && !hwrite;
    assign tk     = fast_src_tick || ext_src_tick;

    // Marks the data phase of a write, when a flag clear can land.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) wr_dp_r <= 1'b0;
        else wr_dp_r <= take_w;
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ********************************************************
    // Assertions
    // ********************************************************
    hresp_okay_a: assert property (hresp == 1'b0)
        else $error("bus response was not okay");
    read_wait_a: assert property (take_r |=> !hreadyout ##1 hreadyout)
        else $error("read data phase did not take two cycles");
    write_nowait_a: assert property (take_w |=> hreadyout)
        else $error("write data phase was stretched");
    upper_zero_a: assert property (hrdata[31:8] == 24'h0)
        else $error("upper read data bits were not zero");
    short_stall_a: assert property (!hreadyout |=> hreadyout)
        else $error("slave stalled for more than one cycle");
    wrap_tick_a: assert property (wrap_event |->
        $past(tk) || $past(tk, 2) || $past(tk, 3))
        else $error("wrap strobe without a source tick");
    match_tick_a: assert property (match_event |->
        $past(tk) || $past(tk, 2) || $past(tk, 3))
        else $error("match strobe without a source tick");
    wrap_pulse_a: assert property (wrap_event |=> !wrap_event)
        else $error("wrap strobe lasted more than one cycle");
    irq_drop_a: assert property ($fell(irq) |-> $past(wr_dp_r))
        else $error("interrupt fell without a register write");

    read_seen_c: cover property (take_r);
    wrap_seen_c: cover property (wrap_event);
    irq_clear_c: cover property ($fell(irq));
endmodule : rtcs_properties

bind rtcs_top rtcs_properties u_rtcs_properties (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .fast_src_tick(fast_src_tick),
    .ext_src_tick(ext_src_tick), .irq(irq), .wrap_event(wrap_event),
    .match_event(match_event)
);

// ==== dv/rtcs_top_tb.sv ====
// Self-checking bench for the real-time counter control block.
module rtcs_top_tb import rtcs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic       w;
        logic [5:0] idx;
        logic [7:0] d;
    } rtcs_row_t;

    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic        fast_src_tick = 1'b0, ext_src_tick = 1'b0;
    logic        dbg_halt = 1'b0, hreadyout, hresp, irq;
    logic        wrap_event, match_event;
    logic [7:0]  haddr = 8'h00, v, a;
    logic [1:0]  htrans = 2'h0, sleep_mode = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, hrdata;
    logic [7:0]  step [1:3] = '{8'h01, 8'h00, 8'h02};
    int          miscompares = 0, total_checks = 0, cycles = 0;
    logic [7:0]  n_wrap = 8'h00, n_match = 8'h00;

    // Reads compare against d; writes store d.
    localparam rtcs_row_t ROWS [25] = '{
        '{1'b0, IDX_CONTROL_A, 8'h00}, '{1'b0, IDX_STATUS, 8'h00},
        '{1'b0, IDX_IRQ_ENABLES, 8'h00}, '{1'b0, IDX_IRQ_FLAGS, 8'h00},
        '{1'b0, IDX_TEMP, 8'h00}, '{1'b0, IDX_PITSTAT, 8'h00},
        '{1'b0, IDX_PERL, 8'hff}, '{1'b0, IDX_PERH, 8'hff},
        '{1'b0, 6'h3f, 8'h00},
        '{1'b1, IDX_IRQ_ENABLES, 8'hff}, '{1'b0, IDX_IRQ_ENABLES, 8'h03},
        '{1'b1, IDX_CONTROL_A, 8'hfe}, '{1'b0, IDX_CONTROL_A, 8'hf8},
        '{1'b1, IDX_TEMP, 8'ha5}, '{1'b0, IDX_TEMP, 8'ha5},
        '{1'b1, IDX_CMPL, 8'h34}, '{1'b0, IDX_TEMP, 8'h34},
        '{1'b1, IDX_CMPH, 8'h12}, '{1'b0, IDX_CMPL, 8'h34},
        '{1'b0, IDX_CMPH, 8'h12}, '{1'b1, IDX_CMPL, 8'h99},
        '{1'b0, IDX_CMPL, 8'h34}, '{1'b0, IDX_STATUS, 8'h09},
        '{1'b1, IDX_STATUS, 8'hff}, '{1'b0, IDX_STATUS, 8'h09}
    };

    rtcs_top u_rtcs_top (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .fast_src_tick(fast_src_tick),
        .ext_src_tick(ext_src_tick), .sleep_mode(sleep_mode),
        .dbg_halt(dbg_halt), .irq(irq), .wrap_event(wrap_event),
        .match_event(match_event)
    );

    always #50 hclk = ~hclk;

    always @(posedge hclk) begin
        cycles++;
        if (cycles == 10000) begin
            miscompares++;
            give_verdict();
        end
    end

    // Strobes last one full cycle, so each falling edge sees a pulse once.
    always @(negedge hclk) begin
        if (wrap_event === 1'b1) begin
            n_wrap <= n_wrap + 8'h01;
        end
        if (match_event === 1'b1) begin
            n_match <= n_match + 8'h01;
        end
    end

    // ********************************************************
    // Tasks
    // ********************************************************
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [5:0] idx,
                       input logic [7:0] wd, output logic [7:0] rd);
        logic rdy;
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {idx, 2'h0};
        // Ready is sampled while settled, ahead of the edge that uses it.
        do begin
            @(negedge hclk);
            rdy = hreadyout;
            @(posedge hclk);
        end while (rdy !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do begin
            @(negedge hclk);
            rdy = hreadyout;
            rd  = hrdata[7:0];
            @(posedge hclk);
        end while (rdy !== 1'b1);
    endtask : bus

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [7:0] junk;
        bus(1'b1, idx, d, junk);
    endtask : wr

    task automatic rd(input logic [5:0] idx, output logic [7:0] d);
        bus(1'b0, idx, 8'h00, d);
    endtask : rd

    task automatic tick(input int n);
        repeat (n) begin
            fast_src_tick <= 1'b1;
            ext_src_tick  <= 1'b1;
            @(posedge hclk);
            fast_src_tick <= 1'b0;
            ext_src_tick  <= 1'b0;
            repeat (3) @(posedge hclk);
        end
    endtask : tick

    task automatic cnt(output logic [7:0] lo);
        logic [7:0] hi;
        rd(IDX_CNTL, lo);
        rd(IDX_CNTH, hi);
        chk("count high", 8'h00, hi);
    endtask : cnt

    task automatic chk_irq(input logic [7:0] exp);
        @(negedge hclk);
        chk("irq", exp, {7'h00, irq});
        @(posedge hclk);
    endtask : chk_irq

    task automatic run_rows(input int lo, input int hi);
        for (int i = lo; i <= hi; i++) begin
            if (ROWS[i].w) begin
                wr(ROWS[i].idx, ROWS[i].d);
            end else begin
                rd(ROWS[i].idx, v);
                chk($sformatf("index %h", ROWS[i].idx), ROWS[i].d, v);
            end
        end
    endtask : run_rows

    // ********************************************************
    // Test sequence
    // ********************************************************
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        run_rows(0, 24);
        chk_irq(8'h00);
        tick(2);
        wr(IDX_PERL, 8'h03);
        wr(IDX_PERH, 8'h00);
        wr(IDX_CMPL, 8'h02);
        wr(IDX_CMPH, 8'h00);
        wr(IDX_CONTROL_A, 8'h01);
        tick(1);
        rd(IDX_STATUS, v);
        chk("busy after one tick", 8'h0d, v);
        tick(1);
        rd(IDX_STATUS, v);
        chk("busy after two ticks", 8'h00, v);
        wr(IDX_IRQ_FLAGS, 8'h03);
        tick(4);
        rd(IDX_IRQ_FLAGS, v);
        chk("flags", 8'h03, v);
        chk("wrap strobes", 8'h01, n_wrap);
        chk("match strobes", 8'h01, n_match);
        chk_irq(8'h01);
        wr(IDX_IRQ_FLAGS, 8'h01);
        wr(IDX_IRQ_FLAGS, 8'h00);
        rd(IDX_IRQ_FLAGS, v);
        chk("flags", 8'h02, v);
        chk_irq(8'h01);
        wr(IDX_IRQ_FLAGS, 8'h02);
        chk_irq(8'h00);
        wr(IDX_IRQ_ENABLES, 8'h00);
        tick(4);
        rd(IDX_IRQ_FLAGS, v);
        chk("masked flags", 8'h03, v);
        chk_irq(8'h00);
        for (int p = 0; p < 3; p++) begin
            wr(IDX_CONTROL_A, {1'b0, 4'(p), 3'h1});
            tick(2);
            cnt(a);
            tick(2 << p);
            cnt(v);
            chk("prescaled count", (a + 8'h02) & 8'h03, v);
        end
        sleep_mode <= 2'h2;
        cnt(a);
        tick(8);
        cnt(v);
        chk("standby hold", a, v);
        sleep_mode <= 2'h1;
        tick(4);
        cnt(v);
        chk("idle run", (a + 8'h01) & 8'h03, v);
        wr(IDX_CONTROL_A, 8'h81);
        tick(2);
        sleep_mode <= 2'h2;
        cnt(a);
        tick(2);
        cnt(v);
        chk("standby run", (a + 8'h02) & 8'h03, v);
        wr(IDX_PITCTRL, 8'h09);
        rd(IDX_PITSTAT, v);
        chk("periodic busy", 8'h01, v);
        tick(2);
        wr(IDX_PITFLAG, 8'h01);
        tick(4);
        rd(IDX_PITFLAG, v);
        chk("periodic flag", 8'h01, v);
        sleep_mode <= 2'h0;
        for (int s = 1; s < 4; s++) begin
            wr(IDX_TICK_SOURCE_SELECT, {6'h00, 2'(s)});
            cnt(a);
            tick(s == 1 ? 32 : 6);
            cnt(v);
            chk("source count", (a + step[s]) & 8'h03, v);
        end
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        run_rows(0, 8);
        chk_irq(8'h00);
        give_verdict();
    end
endmodule : rtcs_top_tb
